// ---- src/pcq_channel.sv ----
// One PWM channel: counter, period update, enable flag and event
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - Later periods restart the counter at one
// - First period counts from zero to period
// - Center-aligned enable raises an event immediately
// - Zero written to period update is ignored
// - Flag stays one a full period after disable
module pcq_channel
   import pcq_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // Control strobes
   input  wire logic              enable_cmd,
   input  wire logic              disable_cmd,
   // Configuration
   input  wire pcq_cfg_type       cfg,
   input  wire pcq_upd_type       period_update_reg,
   // Status and waveform
   output logic                   channel_enabled_flag,
   output logic                   period_event,
   output logic                   pwm_wave
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   pcq_state_type     state_reg;
   pcq_state_type     state_next;
   logic [CNT_W-1:0]  count_reg;
   logic              up_reg;
   logic              center_reg;
   logic [CNT_W-1:0]  period_reg;
   logic [CNT_W-1:0]  pend_reg;
   logic              pend_valid_reg;
   logic [LAG_W-1:0]  lag_reg;
   logic              running;
   logic              enable_start;
   logic              disable_start;
   logic              period_end;
   logic              upd_take;

   assign running       = (state_reg == PCQ_FIRST) || (state_reg == PCQ_RUN);
   assign enable_start  = enable_cmd;
   assign disable_start = disable_cmd && running && !enable_cmd;
   assign upd_take      = period_update_reg.write
                          && (period_update_reg.data != PERIOD_ZERO);

   // Left mode ends at the top, center mode ends back at the restart value
   assign period_end = running && (center_reg ? (!up_reg && count_reg <= CNT_RESTART)
                                              : (up_reg && count_reg >= period_reg));

   ////////////////////////////////////////////////////////////////////////////
   // Channel state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         PCQ_IDLE: begin
            if (enable_start) state_next = PCQ_FIRST;
         end
         PCQ_FIRST: begin
            if (enable_start) state_next = PCQ_FIRST;
            else if (disable_start) state_next = PCQ_LAG;
            else if (period_end) state_next = PCQ_RUN;
         end
         PCQ_RUN: begin
            if (enable_start) state_next = PCQ_FIRST;
            else if (disable_start) state_next = PCQ_LAG;
         end
         PCQ_LAG: begin
            if (enable_start) state_next = PCQ_FIRST;
            else if (lag_reg <= LAG_LAST) state_next = PCQ_IDLE;
         end
         default: state_next = PCQ_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg <= PCQ_IDLE;
      end else if (clk_en) begin
         state_reg <= state_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter
   always_ff @(posedge clk) begin
      if (reset) begin
         count_reg  <= CNT_FIRST;
         up_reg     <= 1'b1;
         center_reg <= 1'b0;
      end else if (clk_en) begin
         if (enable_start) begin
            count_reg  <= CNT_FIRST;
            up_reg     <= 1'b1;
            center_reg <= cfg.center_align_select;
         end else if (running) begin
            if (up_reg) begin
               if (count_reg >= period_reg) begin
                  if (center_reg) begin
                     up_reg    <= 1'b0;
                     count_reg <= count_reg - CNT_RESTART;
                  end else begin
                     count_reg <= CNT_RESTART;
                  end
               end else begin
                  count_reg <= count_reg + CNT_RESTART;
               end
            end else if (count_reg <= CNT_RESTART) begin
               // Bottom turn restarts at one, so later periods lose one cycle
               up_reg    <= 1'b1;
               count_reg <= CNT_RESTART;
            end else begin
               count_reg <= count_reg - CNT_RESTART;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Period and pending update
   always_ff @(posedge clk) begin
      if (reset) begin
         pend_reg       <= PERIOD_RST;
         pend_valid_reg <= 1'b0;
      end else if (clk_en) begin
         if (upd_take) begin
            pend_reg       <= period_update_reg.data;
            pend_valid_reg <= 1'b1;
         end else if (period_end || enable_start) begin
            pend_valid_reg <= 1'b0;
         end
      end
   end

   // Updates land only on a boundary so a period is never cut short
   always_ff @(posedge clk) begin
      if (reset) begin
         period_reg <= PERIOD_RST;
      end else if (clk_en) begin
         if (enable_start) begin
            period_reg <= cfg.period;
         end else if (period_end && pend_valid_reg) begin
            period_reg <= pend_reg;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Enabled flag with its one period lag
   always_ff @(posedge clk) begin
      if (reset) begin
         lag_reg <= LAG_RST;
      end else if (clk_en) begin
         if (disable_start) begin
            lag_reg <= center_reg ? {period_reg, 1'b0} : {1'b0, period_reg};
         end else if (state_reg == PCQ_LAG && lag_reg != LAG_RST) begin
            lag_reg <= lag_reg - LAG_LAST;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         channel_enabled_flag <= 1'b0;
      end else if (clk_en) begin
         channel_enabled_flag <= (state_next != PCQ_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Period event, including the spurious one on a center-aligned enable
   always_ff @(posedge clk) begin
      if (reset) begin
         period_event <= 1'b0;
      end else if (clk_en) begin
         period_event <= period_end || (enable_start && cfg.center_align_select);
      end
   end

   pcq_wave wave_unit (
      .clk      (clk),
      .reset    (reset),
      .clk_en   (clk_en),
      .active   (running),
      .polarity (cfg.polarity),
      .count    (count_reg),
      .duty     (cfg.duty),
      .wave     (pwm_wave)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   sequence left_wrap_s;
      clk_en && running && !center_reg && up_reg && count_reg >= period_reg
         && !enable_start;
   endsequence

   sequence start_s;
      clk_en && enable_start;
   endsequence

   restart_one_a: assert property (left_wrap_s |=> count_reg == CNT_RESTART)
      else $error("counter did not restart at one");

   first_zero_a: assert property (start_s |=> count_reg == CNT_FIRST
                                  && state_reg == PCQ_FIRST)
      else $error("first period did not start at zero");

   center_event_a: assert property (start_s and cfg.center_align_select
                                    |=> period_event)
      else $error("no event on center aligned enable");

   zero_update_a: assert property (clk_en && period_update_reg.write
                                   && period_update_reg.data == PERIOD_ZERO
                                   && !pend_valid_reg |=> !pend_valid_reg)
      else $error("zero period update was taken");

   flag_lag_a: assert property (clk_en && disable_start && period_reg > CNT_RESTART
                                && !center_reg |=> channel_enabled_flag [*2])
      else $error("enabled flag dropped before a full period");

endmodule

// ---- inc/pcq_pkg.sv ----
// Constants and carrier types for the PWM channel counter block
package pcq_pkg;

   localparam int          CNT_W        = 16;
   localparam int          LAG_W        = CNT_W + 1;
   // Counter start value of the very first period after an enable
   localparam logic [15:0] CNT_FIRST    = 16'h0000;
   // Counter restart value at each later period boundary
   localparam logic [15:0] CNT_RESTART  = 16'h0001;
   localparam logic [15:0] PERIOD_RST   = 16'h0000;
   localparam logic [15:0] PERIOD_ZERO  = 16'h0000;
   localparam logic [16:0] LAG_RST      = 17'h00000;
   localparam logic [16:0] LAG_LAST     = 17'h00001;

   // Gray coded along idle -> first -> run -> lag -> idle
   typedef enum logic [1:0] {
      PCQ_IDLE  = 2'h0,
      PCQ_FIRST = 2'h1,
      PCQ_RUN   = 2'h3,
      PCQ_LAG   = 2'h2
   } pcq_state_type;

   // Channel configuration as presented by software
   typedef struct packed {
      logic              center_align_select;
      logic              polarity;
      logic [CNT_W-1:0]  period;
      logic [CNT_W-1:0]  duty;
   } pcq_cfg_type;

   // Period update strobe and its data
   typedef struct packed {
      logic              write;
      logic [CNT_W-1:0]  data;
   } pcq_upd_type;

endpackage

// ---- src/pcq_wave.sv ----
// Duty comparator producing the registered waveform pin
module pcq_wave
   import pcq_pkg::*;
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              clk_en,
   // Compare inputs
   input  wire logic              active,
   input  wire logic              polarity,
   input  wire logic [CNT_W-1:0]  count,
   input  wire logic [CNT_W-1:0]  duty,
   // Waveform
   output logic                   wave
);

   logic wave_next;

   // Idle level is the polarity itself so a stopped channel rests quietly
   always_comb begin
      wave_next = polarity;
      if (active) begin
         wave_next = (count < duty) ^ polarity;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         wave <= 1'b0;
      end else if (clk_en) begin
         wave <= wave_next;
      end
   end

endmodule

// ---- verif/tb.sv ----
// Self-checking bench for the PWM channel counter block
module tb
   import pcq_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic         clk;
   logic         reset;
   logic         clk_en;
   logic         enable_cmd;
   logic         disable_cmd;
   pcq_cfg_type  cfg;
   pcq_upd_type  upd;
   logic         channel_enabled_flag;
   logic         period_event;
   logic         pwm_wave;
   logic [31:0]  lfsr;
   int           mismatches;
   int           check_count;
   int           gap;
   int           last_gap;
   int           nev;
   int           p;
   int           q;
   int           t;
   int           n;
   logic         held;

   pcq_channel pcq_channel_inst (
      .clk                  (clk),
      .reset                (reset),
      .clk_en               (clk_en),
      .enable_cmd           (enable_cmd),
      .disable_cmd          (disable_cmd),
      .cfg                  (cfg),
      .period_update_reg    (upd),
      .channel_enabled_flag (channel_enabled_flag),
      .period_event         (period_event),
      .pwm_wave             (pwm_wave)
   );

   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////////
   // Cycles between events, restarted by each enable
   always @(posedge clk) begin
      if (enable_cmd) begin
         gap <= 0;
      end else if (period_event === 1'b1) begin
         last_gap <= gap;
         gap      <= 1;
         nev      <= nev + 1;
      end else begin
         gap <= gap + 1;
      end
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   // First period is one cycle longer than every later one
   function automatic int period_len(input int per, input logic ctr, input logic first);
      return (ctr ? 2 * per - 1 : per) + int'(first);
   endfunction

   function automatic int lag_len(input int per, input logic ctr);
      return ctr ? 2 * per : per;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic rnd(output int v, input int lo, input int span);
      lfsr = lfsr_next(lfsr);
      v = lo + int'(lfsr[15:0]) % span;
   endtask

   task automatic start(input int per, input logic ctr);
      lfsr = lfsr_next(lfsr);
      cfg.center_align_select = ctr;
      cfg.period = per[15:0];
      cfg.duty = {12'h000, lfsr[3:0]};
      cfg.polarity = lfsr[8];
      enable_cmd = 1'b1;
      @(negedge clk);
      enable_cmd = 1'b0;
   endtask

   task automatic next_ev;
      int k;
      int w;
      k = nev;
      w = 0;
      while (nev == k && w < 3000) begin
         @(negedge clk);
         w++;
      end
   endtask

   task automatic update(input int v);
      upd.write = 1'b1;
      upd.data = v[15:0];
      @(negedge clk);
      upd.write = 1'b0;
   endtask

   // Flag is only trusted once the lag has run out
   task automatic stop_and_lag(input int per, input logic ctr);
      disable_cmd = 1'b1;
      @(negedge clk);
      disable_cmd = 1'b0;
      t = 0;
      while (channel_enabled_flag === 1'b1 && t < 3000) begin
         @(negedge clk);
         t++;
      end
      check(32'(t >= lag_len(per, ctr) && t <= lag_len(per, ctr) + 1), 32'h1);
      check(32'(pwm_wave), 32'(cfg.polarity));
   endtask

   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      reset = 1'b1;
      clk_en = 1'b1;
      enable_cmd = 1'b0;
      disable_cmd = 1'b0;
      cfg = '0;
      upd = '0;
      lfsr = 32'hFEBFB5DF;
      mismatches = 0;
      check_count = 0;
      gap = 0;
      last_gap = 0;
      nev = 0;
      repeat (3) @(negedge clk);
      check(32'(channel_enabled_flag), 32'h0);
      check(32'(period_event), 32'h0);
      check(32'(pwm_wave), 32'h0);
      reset = 1'b0;
      for (int i = 0; i < 4; i++) begin
         rnd(p, 3, 14);
         rnd(q, 3, 14);
         start(p, 1'b0);
         next_ev;
         check(last_gap, period_len(p, 1'b0, 1'b1));
         next_ev;
         check(last_gap, p);
         // Zero update on purpose: it must be dropped
         update(0);
         next_ev;
         check(last_gap, p);
         next_ev;
         check(last_gap, p);
         update(q);
         next_ev;
         check(last_gap, p);
         next_ev;
         check(last_gap, q);
         stop_and_lag(q, 1'b0);
      end
      // Spurious event shows long before any period could end
      rnd(p, 4, 10);
      start(p, 1'b1);
      next_ev;
      check(32'(last_gap <= 3), 32'h1);
      // Frozen cycles stretch the first period by exactly that many
      rnd(n, 1, 5);
      held = pwm_wave;
      clk_en = 1'b0;
      repeat (n) @(negedge clk);
      check(32'(pwm_wave), 32'(held));
      clk_en = 1'b1;
      next_ev;
      check(last_gap, period_len(p, 1'b1, 1'b1) + n);
      next_ev;
      check(last_gap, period_len(p, 1'b1, 1'b0));
      stop_and_lag(p, 1'b1);
      print_verdict;
   end

   initial begin
      #200000;
      mismatches++;
      print_verdict;
   end
endmodule
